// *** aom_angle_output_mapper.sv ***
// angle output mapper: zero offset, linear slope, clamping, diagnostic band,
// lockable config memory written by the one-wire decoder, AXI4-Lite slave.
// assumes angle samples and one-wire commands come from logic on sys_clk.
//
// Contract
// - output select 0 drives the analog level from the measured angle.
// - output select 1 hands the measured angle to the SENT framer; the code hands it the mapped output value instead.
// - the angle is mapped linearly with a positive or negative slope.
// - positive slope, angle above maximum and below switch angle gives the upper clamp.
// - positive slope, angle at or beyond the switch angle gives the lower clamp; the code gives it only when the angle is also above maximum.
// - negative slope swaps the upper and lower clamp levels.
// - analog codes below 4 or above 96 percent of supply flag a detected error.
// - the angle is taken relative to a programmable zero and wraps every half turn.
// - once the lock bit is set no config memory word can change.
// - eight customer words of 12 bits are kept in the config memory.
// - the config memory is written only through the one-wire port.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module aom_angle_output_mapper #(
  parameter int ADDR_W = aom_pkg::ADDR_W
) (
  input wire logic sys_clk, // 25 MHz clock
  input wire logic resetn, // synchronous reset, low active
  input wire logic [aom_pkg::ANG_W-1:0] angleIn, // angle code, half turn
  input wire logic angleValid, // one pulse per computed angle
  input wire logic owiWrEn, // one-wire write strobe
  input wire logic [aom_pkg::IDX_W-1:0] owiAddr, // one-wire word index
  input wire logic [aom_pkg::CFG_W-1:0] owiWrData, // one-wire write data
  output logic [aom_pkg::CFG_W-1:0] owiRdData, // word at owiAddr
  output logic owiReject, // write refused, locked
  output logic [aom_pkg::ANG_W-1:0] dacCode, // analog level code
  output logic [aom_pkg::ANG_W-1:0] sentValue, // value for SENT framer
  output logic sentStrobe, // new sentValue
  output logic diagError, // analog code in diagnostic band
  output logic irq, // level interrupt
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [aom_pkg::DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [aom_pkg::DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  typedef struct packed {
    logic [aom_pkg::CFG_WORDS-1:0][aom_pkg::CFG_W-1:0] cfg;
    logic [aom_pkg::ANG_W-1:0] relAngle;
    logic relValid;
    logic [aom_pkg::ANG_W-1:0] lastValue;
    logic [aom_pkg::ANG_W-1:0] dacCode;
    logic [aom_pkg::ANG_W-1:0] sentValue;
    logic sentStrobe;
    logic diagError;
    logic [aom_pkg::EV_W-1:0] status;
    logic [aom_pkg::EV_W-1:0] mask;
    logic irq;
    logic [aom_pkg::CFG_W-1:0] owiRdData;
    logic owiReject;
    logic awReady;
    logic wReady;
    logic awHave;
    logic wHave;
    logic [ADDR_W-1:0] awAddr;
    logic [aom_pkg::DATA_W-1:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [aom_pkg::DATA_W-1:0] rData;
    logic [1:0] rResp;
  } aom_state_t;

  aom_state_t st;
  aom_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // angle to output value; out-of-range regions pick a clamp level
  function automatic logic [aom_pkg::ANG_W-1:0] mapAngle(
    input logic [aom_pkg::ANG_W-1:0] rel,
    input logic [aom_pkg::ANG_W-1:0] maxA,
    input logic [aom_pkg::ANG_W-1:0] swA,
    input logic [aom_pkg::ANG_W-1:0] up,
    input logic [aom_pkg::ANG_W-1:0] lo,
    input logic [aom_pkg::CFG_W-1:0] gain,
    input logic neg
  );
    logic [aom_pkg::ANG_W+aom_pkg::CFG_W-1:0] prod;
    logic [aom_pkg::ANG_W:0] scaled;
    logic [aom_pkg::ANG_W:0] sum;
    logic [aom_pkg::ANG_W:0] span;
    logic [aom_pkg::ANG_W-1:0] res;
    prod = {{aom_pkg::CFG_W{1'b0}}, rel} * {{aom_pkg::ANG_W{1'b0}}, gain};
    // large gains saturate instead of wrapping
    if (|prod[aom_pkg::ANG_W+aom_pkg::CFG_W-1:aom_pkg::GAIN_SHIFT+aom_pkg::ANG_W+1]) begin
      scaled = {(aom_pkg::ANG_W+1){1'b1}};
    end else begin
      scaled = prod[aom_pkg::GAIN_SHIFT +: aom_pkg::ANG_W+1];
    end
    sum = {1'b0, lo} + scaled;
    span = {1'b0, up} - {1'b0, lo};
    if (rel > maxA) begin
      if (rel < swA) begin
        res = neg ? lo : up;
      end else begin
        res = neg ? up : lo;
      end
    end else if (neg) begin
      res = (scaled > span) ? lo : (up - scaled[aom_pkg::ANG_W-1:0]);
    end else begin
      res = (sum > {1'b0, up}) ? up : sum[aom_pkg::ANG_W-1:0];
    end
    return res;
  endfunction

  // register byte address to config word index
  function automatic logic [aom_pkg::IDX_W-1:0] cfgIndex(input logic [ADDR_W-1:0] a);
    return a[aom_pkg::IDX_W+1:2];
  endfunction

  // config words are readable only; other words by address
  function automatic logic [aom_pkg::DATA_W-1:0] readWord(input aom_state_t s, input logic [ADDR_W-1:0] a);
    logic [aom_pkg::DATA_W-1:0] d;
    d = '0;
    if (a < aom_pkg::CFG_END) begin
      d[aom_pkg::CFG_W-1:0] = s.cfg[cfgIndex(a)];
    end else if (a == aom_pkg::OFS_STATUS) begin
      d[aom_pkg::EV_W-1:0] = s.status;
    end else if (a == aom_pkg::OFS_MASK) begin
      d[aom_pkg::EV_W-1:0] = s.mask;
    end else if (a == aom_pkg::OFS_LIVE) begin
      d[aom_pkg::ANG_W-1:0] = s.lastValue;
    end
    return d;
  endfunction

  function automatic logic addrKnown(input logic [ADDR_W-1:0] a);
    return (a < aom_pkg::CFG_END) || (a == aom_pkg::OFS_STATUS) || (a == aom_pkg::OFS_MASK) ||
           (a == aom_pkg::OFS_LIVE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole block
  always_comb begin
    logic [aom_pkg::EV_W-1:0] evt;
    logic [aom_pkg::EV_W-1:0] clr;
    logic outSel;
    logic [aom_pkg::ANG_W-1:0] val;
    evt = '0;
    clr = '0;
    val = '0;
    next_st = st;
    next_st.sentStrobe = 1'b0;
    next_st.owiReject = 1'b0;
    outSel = st.cfg[aom_pkg::IDX_SYS][aom_pkg::BIT_OUTSEL];
    // stage one: relative angle; the 12-bit difference wraps each half turn
    next_st.relValid = angleValid;
    if (angleValid) begin
      next_st.relAngle = angleIn - st.cfg[aom_pkg::IDX_ZERO][aom_pkg::ANG_W-1:0];
    end
    // stage two: every sample refreshes the selected output
    if (st.relValid) begin
      val = mapAngle(st.relAngle, st.cfg[aom_pkg::IDX_MAX][aom_pkg::ANG_W-1:0],
                     st.cfg[aom_pkg::IDX_SW][aom_pkg::ANG_W-1:0], st.cfg[aom_pkg::IDX_UP][aom_pkg::ANG_W-1:0],
                     st.cfg[aom_pkg::IDX_LO][aom_pkg::ANG_W-1:0], st.cfg[aom_pkg::IDX_GAIN],
                     st.cfg[aom_pkg::IDX_SYS][aom_pkg::BIT_SLOPE]);
      next_st.lastValue = val;
      evt[aom_pkg::EV_SAMPLE] = 1'b1;
      if (outSel) begin
        next_st.sentValue = val;
        next_st.sentStrobe = 1'b1;
      end else begin
        next_st.dacCode = val;
      end
    end
    // diagnostic band only means something on the analog pin
    next_st.diagError = !outSel && ((next_st.dacCode < aom_pkg::DIAG_LO_CODE) ||
                                    (next_st.dacCode > aom_pkg::DIAG_HI_CODE));
    evt[aom_pkg::EV_DIAG] = next_st.diagError;
    // one-wire access is the only write path into config memory
    next_st.owiRdData = st.cfg[owiAddr];
    if (owiWrEn) begin
      if (st.cfg[aom_pkg::IDX_SYS][aom_pkg::BIT_LOCK]) begin
        next_st.owiReject = 1'b1;
        evt[aom_pkg::EV_REJECT] = 1'b1;
      end else if (owiAddr >= aom_pkg::IDX_CUST0) begin
        next_st.cfg[owiAddr] = {{(aom_pkg::CFG_W-aom_pkg::CUST_W){1'b0}},
                                owiWrData[aom_pkg::CUST_W-1:0]};
      end else begin
        next_st.cfg[owiAddr] = owiWrData;
      end
    end
    // bus write channels, taken in either order
    if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end
    if (s_axi_awvalid && st.awReady) begin
      next_st.awHave = 1'b1;
      next_st.awReady = 1'b0;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wReady) begin
      next_st.wHave = 1'b1;
      next_st.wReady = 1'b0;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    if (st.awHave && st.wHave && !st.bValid) begin
      next_st.awHave = 1'b0;
      next_st.wHave = 1'b0;
      next_st.awReady = 1'b1;
      next_st.wReady = 1'b1;
      next_st.bValid = 1'b1;
      next_st.bResp = aom_pkg::RESP_OKAY;
      if (st.awAddr == aom_pkg::OFS_STATUS) begin
        clr = st.wStrb[0] ? st.wData[aom_pkg::EV_W-1:0] : '0;
      end else if (st.awAddr == aom_pkg::OFS_MASK) begin
        if (st.wStrb[0]) begin
          next_st.mask = st.wData[aom_pkg::EV_W-1:0];
        end
      end else begin
        // config words cannot be written from the bus
        next_st.bResp = aom_pkg::RESP_SLVERR;
      end
    end
    // new events win over a write-one-to-clear in the same cycle
    next_st.status = (st.status & ~clr) | evt;
    next_st.irq = |(next_st.status & next_st.mask);
    // bus read channel: one cycle from address to data
    if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
      next_st.arReady = 1'b1;
    end
    if (s_axi_arvalid && st.arReady) begin
      next_st.arReady = 1'b0;
      next_st.rValid = 1'b1;
      next_st.rData = readWord(st, s_axi_araddr);
      next_st.rResp = addrKnown(s_axi_araddr) ? aom_pkg::RESP_OKAY : aom_pkg::RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register with config defaults at reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st <= '0;
      st.cfg[aom_pkg::IDX_MAX] <= aom_pkg::RST_MAX;
      st.cfg[aom_pkg::IDX_SW] <= aom_pkg::RST_SW;
      st.cfg[aom_pkg::IDX_UP] <= aom_pkg::RST_UP;
      st.cfg[aom_pkg::IDX_LO] <= aom_pkg::RST_LO;
      st.cfg[aom_pkg::IDX_GAIN] <= aom_pkg::RST_GAIN;
      st.awReady <= 1'b1;
      st.wReady <= 1'b1;
      st.arReady <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs come straight from state flops
  assign owiRdData = st.owiRdData;
  assign owiReject = st.owiReject;
  assign dacCode = st.dacCode;
  assign sentValue = st.sentValue;
  assign sentStrobe = st.sentStrobe;
  assign diagError = st.diagError;
  assign irq = st.irq;
  assign s_axi_awready = st.awReady;
  assign s_axi_wready = st.wReady;
  assign s_axi_bresp = st.bResp;
  assign s_axi_bvalid = st.bValid;
  assign s_axi_arready = st.arReady;
  assign s_axi_rdata = st.rData;
  assign s_axi_rresp = st.rResp;
  assign s_axi_rvalid = st.rValid;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  logic slopeNeg;
  logic [aom_pkg::ANG_W-1:0] cMax;
  logic [aom_pkg::ANG_W-1:0] cSw;
  logic [aom_pkg::ANG_W-1:0] cUp;
  logic [aom_pkg::ANG_W-1:0] cLo;
  assign slopeNeg = st.cfg[aom_pkg::IDX_SYS][aom_pkg::BIT_SLOPE];
  assign cMax = st.cfg[aom_pkg::IDX_MAX][aom_pkg::ANG_W-1:0];
  assign cSw = st.cfg[aom_pkg::IDX_SW][aom_pkg::ANG_W-1:0];
  assign cUp = st.cfg[aom_pkg::IDX_UP][aom_pkg::ANG_W-1:0];
  assign cLo = st.cfg[aom_pkg::IDX_LO][aom_pkg::ANG_W-1:0];

  property p_analog_path;
    st.relValid && !st.cfg[aom_pkg::IDX_SYS][aom_pkg::BIT_OUTSEL] |=> !sentStrobe && dacCode == st.lastValue;
  endproperty
  a_analog_path: assert property (p_analog_path) else $error("analog mode did not update dac code");

  property p_sent_path;
    st.relValid && st.cfg[aom_pkg::IDX_SYS][aom_pkg::BIT_OUTSEL] |=> sentStrobe && sentValue == st.lastValue;
  endproperty
  a_sent_path: assert property (p_sent_path) else $error("sent mode did not strobe value");

  property p_zero_rel;
    st.relValid && !slopeNeg && st.relAngle == '0 && cLo <= cUp && $stable(st.cfg) |=> st.lastValue == $past(cLo);
  endproperty
  a_zero_rel: assert property (p_zero_rel) else $error("zero angle not at lower level");

  property p_upper_clamp;
    st.relValid && !slopeNeg && st.relAngle > cMax && st.relAngle < cSw |=> st.lastValue == $past(cUp);
  endproperty
  a_upper_clamp: assert property (p_upper_clamp) else $error("upper clamp missing");

  property p_lower_clamp;
    st.relValid && !slopeNeg && st.relAngle > cMax && st.relAngle >= cSw |=> st.lastValue == $past(cLo);
  endproperty
  a_lower_clamp: assert property (p_lower_clamp) else $error("lower clamp missing");

  property p_neg_swap;
    st.relValid && slopeNeg && st.relAngle > cMax && st.relAngle < cSw |=> st.lastValue == $past(cLo);
  endproperty
  a_neg_swap: assert property (p_neg_swap) else $error("negative slope clamp not swapped");

  property p_diag_band;
    diagError |-> (dacCode < aom_pkg::DIAG_LO_CODE || dacCode > aom_pkg::DIAG_HI_CODE);
  endproperty
  a_diag_band: assert property (p_diag_band) else $error("diag flag outside band");

  property p_rel_angle;
    angleValid |=> st.relValid && st.relAngle == $past(angleIn - st.cfg[aom_pkg::IDX_ZERO][aom_pkg::ANG_W-1:0]);
  endproperty
  a_rel_angle: assert property (p_rel_angle) else $error("relative angle wrong");

  property p_lock;
    st.cfg[aom_pkg::IDX_SYS][aom_pkg::BIT_LOCK] |=> $stable(st.cfg) && (owiReject == $past(owiWrEn));
  endproperty
  a_lock: assert property (p_lock) else $error("locked config memory changed");

  property p_cust_width;
    owiWrEn && owiAddr >= aom_pkg::IDX_CUST0 |=> st.cfg[$past(owiAddr)][aom_pkg::CFG_W-1:aom_pkg::CUST_W] == '0;
  endproperty
  a_cust_width: assert property (p_cust_width) else $error("customer word wider than 12 bits");

  property p_bus_no_cfg;
    st.awHave && st.wHave && !st.bValid && st.awAddr < aom_pkg::CFG_END |=> $stable(st.cfg) || $past(owiWrEn);
  endproperty
  a_bus_no_cfg: assert property (p_bus_no_cfg) else $error("bus changed config memory");

  property p_refresh;
    angleValid |-> ##2 st.status[aom_pkg::EV_SAMPLE];
  endproperty
  a_refresh: assert property (p_refresh) else $error("sample did not refresh output");

  c_sent: cover property (st.relValid && st.cfg[aom_pkg::IDX_SYS][aom_pkg::BIT_OUTSEL] ##1 sentStrobe);
  c_clamp_low: cover property (st.relValid && st.relAngle > cMax && st.relAngle >= cSw);
  c_lock_reject: cover property (owiReject);
  c_irq: cover property (irq);
endmodule
`default_nettype wire

// *** aom_pkg.sv ***
// constants shared by the angle output mapper: config word map, bus map,
// field positions, reset values and diagnostic band limits.
// assumes a 12-bit angle code that spans half a turn.
package aom_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ANG_W = 12;
  localparam int CFG_W = 16;
  localparam int CFG_WORDS = 16;
  localparam int IDX_W = 4;
  // config memory word indices
  localparam logic [IDX_W-1:0] IDX_SYS = 4'h0;
  localparam logic [IDX_W-1:0] IDX_ZERO = 4'h1;
  localparam logic [IDX_W-1:0] IDX_MAX = 4'h2;
  localparam logic [IDX_W-1:0] IDX_SW = 4'h3;
  localparam logic [IDX_W-1:0] IDX_UP = 4'h4;
  localparam logic [IDX_W-1:0] IDX_LO = 4'h5;
  localparam logic [IDX_W-1:0] IDX_GAIN = 4'h6;
  localparam logic [IDX_W-1:0] IDX_CUST0 = 4'h8;
  localparam int CUST_W = 12;
  // system settings bits and gain shift
  localparam int BIT_OUTSEL = 12;
  localparam int BIT_SLOPE = 13;
  localparam int BIT_LOCK = 15;
  localparam int GAIN_SHIFT = 12;
  // reset contents of the config memory
  localparam logic [CFG_W-1:0] RST_MAX = 16'h0FFF;
  localparam logic [CFG_W-1:0] RST_SW = 16'h0FFF;
  localparam logic [CFG_W-1:0] RST_UP = 16'h0E66;
  localparam logic [CFG_W-1:0] RST_LO = 16'h019A;
  localparam logic [CFG_W-1:0] RST_GAIN = 16'h1000;
  // bus byte addresses beyond the config window, and bus response codes
  localparam logic [ADDR_W-1:0] CFG_END = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_LIVE = 8'h48;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // event bits
  localparam int EV_W = 3;
  localparam int EV_SAMPLE = 0;
  localparam int EV_DIAG = 1;
  localparam int EV_REJECT = 2;
  // diagnostic band, percent of full scale, and derived codes
  localparam int DIAG_LO_PCT = 4;
  localparam int DIAG_HI_PCT = 96;
  localparam int FULL_SCALE = 4096;
  localparam logic [ANG_W-1:0] DIAG_LO_CODE = ANG_W'((DIAG_LO_PCT * FULL_SCALE + 99) / 100);
  localparam logic [ANG_W-1:0] DIAG_HI_CODE = ANG_W'((DIAG_HI_PCT * FULL_SCALE) / 100);
endpackage

// *** aom_ecu_model.sv ***
// engine controller model: the receiving end of the sensor output pin.
// assumes it is clocked by sys_clk and only listens to the mapper outputs.
`timescale 1ns/1ps
`default_nettype none
module aom_ecu_model (
  input wire logic sys_clk, // same clock as the mapper
  input wire logic [aom_pkg::ANG_W-1:0] sentValue, // value from SENT framer
  input wire logic sentStrobe, // new value pulse
  output logic [aom_pkg::ANG_W-1:0] lastSent, // last value taken off the wire
  output logic [15:0] sentCount // frames received
);
  ////////////////////////////////////////////////////////////////////////////
  // take a value only on its strobe; a stale value between frames is ignored
  // one process owns both outputs, so each has a single driver
  initial begin
    lastSent = 12'h000;
    sentCount = 16'h0000;
    forever begin
      @(posedge sys_clk);
      if (sentStrobe === 1'b1) begin
        lastSent <= sentValue;
        sentCount <= sentCount + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// *** angle_output_mapper_tb.sv ***
// self-checking bench for the angle output mapper: AXI4-Lite and one-wire
// tasks, angle samples, partner model on the SENT side.
// assumes the package and the mapper are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module angle_output_mapper_tb;
  logic sysClk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] angleIn = 12'h000;
  logic angleValid = 1'b0;
  logic owiWrEn = 1'b0;
  logic [3:0] owiAddr = 4'h0;
  logic [15:0] owiWrData = 16'h0000;
  logic [15:0] owiRdData;
  logic owiReject;
  logic [11:0] dacCode, sentValue, lastSent;
  logic sentStrobe, diagError, irq;
  logic [15:0] sentCount;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [1:0] rsp;
  int nMismatch = 0;
  int samplesChecked = 0;
  int i, k;
  logic [11:0] angTab [6] = '{12'h300, 12'hA00, 12'hD00, 12'hE00, 12'h900, 12'h050};

  always #20 sysClk = ~sysClk;

  aom_angle_output_mapper u_aom_angle_output_mapper (.sys_clk(sysClk), .resetn(resetn), .angleIn(angleIn),
    .angleValid(angleValid), .owiWrEn(owiWrEn), .owiAddr(owiAddr), .owiWrData(owiWrData),
    .owiRdData(owiRdData), .owiReject(owiReject), .dacCode(dacCode), .sentValue(sentValue),
    .sentStrobe(sentStrobe), .diagError(diagError), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  aom_ecu_model u_aom_ecu_model (.sys_clk(sysClk), .sentValue(sentValue), .sentStrobe(sentStrobe),
    .lastSent(lastSent), .sentCount(sentCount));

  ////////////////////////////////////////////////////////////////////////////
  // compare, verdict and bus tasks; every bus, port and sample task starts on a fresh edge
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // values read right after the edge are the ones the edge sampled
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sysClk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sysClk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sysClk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sysClk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task one_wire_port(input logic [3:0] a, input logic [15:0] d);
    @(posedge sysClk);
    owiWrEn <= 1'b1;
    owiAddr <= a;
    owiWrData <= d;
    @(posedge sysClk);
    owiWrEn <= 1'b0;
    #1;
  endtask
  task owird(input logic [3:0] a, output logic [15:0] d);
    @(posedge sysClk);
    owiAddr <= a;
    repeat (2) @(posedge sysClk);
    #1 d = owiRdData;
  endtask
  // one sample; outputs settle one edge after the taking edge
  task angle(input logic [11:0] a);
    @(posedge sysClk);
    angleIn <= a;
    angleValid <= 1'b1;
    @(posedge sysClk);
    angleValid <= 1'b0;
    @(posedge sysClk);
    #1;
  endtask
  // expected level at unity gain for zero 0x100, max 0x800, switch 0xC00
  function automatic logic [11:0] mapExp(input logic [11:0] a, input logic [11:0] up,
    input logic [11:0] lo, input logic neg);
    logic [11:0] rel;
    rel = a - 12'h100;
    if (rel > 12'h800 && rel < 12'hC00) return neg ? lo : up;
    if (rel > 12'h800) return neg ? up : lo;
    if (neg) return (up - rel < lo || rel > up) ? lo : up - rel;
    return (13'(lo) + 13'(rel) > 13'(up)) ? up : lo + rel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // watchdog sized well past the couple of hundred cycles the tests take
  initial begin
    #(40 * 20000);
    nMismatch++;
    finish_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [15:0] ow;
    repeat (3) @(posedge sysClk);
    resetn <= 1'b1;
    axr(8'h08, rd, rsp); chk(rd, 32'h00000FFF);
    axr(8'h0C, rd, rsp); chk(rd, 32'h00000FFF);
    axr(8'h10, rd, rsp); chk(rd, 32'h00000E66);
    axr(8'h14, rd, rsp); chk(rd, 32'h0000019A);
    axr(8'h20, rd, rsp); chk(rd, 32'h00000000);
    axr(8'h4C, rd, rsp); chk(rd, 32'h00000000);
    chk(rsp, aom_pkg::RESP_SLVERR);
    axw(8'h08, 32'h00000123, rsp); chk(rsp, aom_pkg::RESP_SLVERR);
    axr(8'h08, rd, rsp); chk(rd, 32'h00000FFF);
    one_wire_port(aom_pkg::IDX_ZERO, 16'h0100);
    one_wire_port(aom_pkg::IDX_MAX, 16'h0800);
    one_wire_port(aom_pkg::IDX_SW, 16'h0C00);
    one_wire_port(aom_pkg::IDX_CUST0 + 4'h7, 16'hFABC);
    owird(aom_pkg::IDX_CUST0 + 4'h7, ow); chk(ow, 16'h0ABC);
    axr(8'h3C, rd, rsp); chk(rd, 32'h00000ABC);
    for (k = 0; k < 2; k++) begin
      one_wire_port(aom_pkg::IDX_SYS, k ? 16'h2000 : 16'h0000);
      for (i = 0; i < 6; i++) begin
        angle(angTab[i]);
        chk(dacCode, mapExp(angTab[i], 12'hE66, 12'h19A, k[0]));
      end
    end
    one_wire_port(aom_pkg::IDX_SYS, 16'h1000);
    angle(12'h400);
    chk(sentValue, 12'h49A);
    chk(sentStrobe, 1'b1);
    chk(dacCode, mapExp(12'h050, 12'hE66, 12'h19A, 1'b1));
    @(posedge sysClk);
    #1 chk(lastSent, 12'h49A);
    chk(sentCount, 16'h0001);
    one_wire_port(aom_pkg::IDX_SYS, 16'h0000);
    one_wire_port(aom_pkg::IDX_LO, 16'h0050);
    one_wire_port(aom_pkg::IDX_UP, 16'h0F80);
    angle(12'h100); chk({dacCode, diagError}, {12'h050, 1'b1});
    angle(12'h900); chk({dacCode, diagError}, {12'h850, 1'b0});
    angle(12'hA00); chk({dacCode, diagError}, {12'hF80, 1'b1});
    axr(aom_pkg::OFS_LIVE, rd, rsp); chk(rd, 32'h00000F80);
    axw(aom_pkg::OFS_MASK, 32'h00000001, rsp); chk(rsp, aom_pkg::RESP_OKAY);
    axw(aom_pkg::OFS_STATUS, 32'h00000007, rsp);
    repeat (3) @(posedge sysClk);
    #1 chk(irq, 1'b0);
    angle(12'h300);
    repeat (2) @(posedge sysClk);
    #1 chk(irq, 1'b1);
    axr(aom_pkg::OFS_STATUS, rd, rsp); chk(rd & 32'h1, 32'h1);
    axw(aom_pkg::OFS_MASK, 32'h00000000, rsp);
    repeat (3) @(posedge sysClk);
    #1 chk(irq, 1'b0);
    // a write with byte lane 0 off must leave the mask alone
    wstrb <= 4'h0;
    axw(aom_pkg::OFS_MASK, 32'h00000007, rsp); chk(rsp, aom_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    axr(aom_pkg::OFS_MASK, rd, rsp); chk(rd, 32'h00000000);
    one_wire_port(aom_pkg::IDX_SYS, 16'h8000);
    one_wire_port(aom_pkg::IDX_CUST0 + 4'h7, 16'h0123); chk(owiReject, 1'b1);
    one_wire_port(aom_pkg::IDX_SYS, 16'h0000); chk(owiReject, 1'b1);
    owird(aom_pkg::IDX_CUST0 + 4'h7, ow); chk(ow, 16'h0ABC);
    owird(aom_pkg::IDX_SYS, ow); chk(ow, 16'h8000);
    axr(aom_pkg::OFS_STATUS, rd, rsp); chk(rd & 32'h4, 32'h4);
    finish_test;
  end
endmodule
`default_nettype wire
